// >>> verilog/gdcfg_pkg.sv
// gdcfg_pkg: shared constants, types and decode functions of the gate driver configuration bank
package gdcfg_pkg;

  localparam int unsigned CLK_MHZ        = 200;

  // register offsets and reset values
  localparam logic [3:0]  ADDR_DRV_CTRL  = 4'h2;
  localparam logic [3:0]  ADDR_HS_GATE   = 4'h3;
  localparam logic [3:0]  ADDR_LS_GATE   = 4'h4;
  localparam logic [3:0]  ADDR_OCP_CTRL  = 4'h5;
  localparam logic [10:0] RST_DRV_CTRL   = 11'h000;
  localparam logic [10:0] RST_HS_GATE    = 11'h377;
  localparam logic [10:0] RST_LS_GATE    = 11'h777;
  localparam logic [10:0] RST_OCP_CTRL   = 11'h145;

  // driver_control fields
  localparam int unsigned F_CLEAR        = 0;
  localparam int unsigned F_BRAKE        = 1;
  localparam int unsigned F_COAST        = 2;
  localparam int unsigned F_DIR          = 3;
  localparam int unsigned F_RECT         = 4;
  localparam int unsigned F_PWM_MODE     = 5;
  localparam int unsigned F_WARN_REP     = 7;
  localparam int unsigned F_GATE_DIS     = 8;
  localparam int unsigned F_PUMP_DIS     = 9;
  localparam logic [10:0] LOCKED_WR_MASK = 11'h007;

  // gate drive fields
  localparam int unsigned F_SINK         = 0;
  localparam int unsigned F_SOURCE       = 4;
  localparam int unsigned F_LOCK         = 8;
  localparam int unsigned F_DRIVE_TIME   = 8;
  localparam int unsigned F_CYCLE_CLR    = 10;
  localparam logic [7:0]  HS_STORE_MASK  = 8'hff;
  localparam logic [2:0]  LOCK_KEY       = 3'h6;
  localparam logic [2:0]  UNLOCK_KEY     = 3'h3;

  // overcurrent_control fields
  localparam int unsigned F_THRESH       = 0;
  localparam int unsigned F_SCOPE        = 5;
  localparam int unsigned F_OC_RESP      = 6;
  localparam int unsigned F_DEAD         = 8;
  localparam int unsigned F_RETRY_SEL    = 10;
  localparam logic [2:0]  THRESH_OFF     = 3'h7;

  // times in their own units, cycle counts derived from the clock rate
  localparam int unsigned DRIVE_BASE_NS  = 500;
  localparam int unsigned DEAD_BASE_NS   = 50;
  localparam int unsigned RETRY_LONG_US  = 4000;
  localparam int unsigned RETRY_SHORT_US = 50;
  localparam int unsigned DRIVE_BASE_CYC = DRIVE_BASE_NS * CLK_MHZ / 1000;
  localparam int unsigned DEAD_BASE_CYC  = DEAD_BASE_NS * CLK_MHZ / 1000;
  localparam int unsigned RETRY_LONG_CYC = RETRY_LONG_US * CLK_MHZ;
  localparam int unsigned RETRY_SHRT_CYC = RETRY_SHORT_US * CLK_MHZ;

  typedef enum logic [3:0] {PWM_SIX = 4'h1, PWM_THREE = 4'h2, PWM_SINGLE = 4'h4, PWM_INDEP = 4'h8} gdcfg_pwm_t;
  typedef enum logic [1:0] {OC_LATCH = 2'h0, OC_RETRY = 2'h1, OC_REPORT = 2'h2, OC_IGNORE = 2'h3} gdcfg_ocr_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [10:0] wdata;
  } gdcfg_req_t;

  typedef struct packed {
    logic        pump_uv;
    logic        gate_fault;
    logic        overtemp_warning;
    logic [2:0]  drain_source_overcurrent;
    logic [2:0]  sense_overcurrent;
    logic        pwm_edge;
  } gdcfg_fault_in_t;

  typedef struct packed {
    logic [8:0]  high_source_ma;
    logic [8:0]  high_sink_ma;
    logic [8:0]  low_source_ma;
    logic [8:0]  low_sink_ma;
    logic [15:0] drive_cycles;
    logic [15:0] dead_cycles;
  } gdcfg_gate_t;

  function automatic logic [8:0] gdcfg_source_ma(input logic [2:0] code);
    case (code)
      3'h0, 3'h1: return 9'd15;
      3'h2:       return 9'd45;
      3'h3:       return 9'd60;
      3'h4:       return 9'd90;
      3'h5:       return 9'd105;
      3'h6:       return 9'd135;
      default:    return 9'd150;
    endcase
  endfunction

  function automatic logic [8:0] gdcfg_sink_ma(input logic [2:0] code);
    case (code)
      3'h0, 3'h1: return 9'd30;
      3'h2:       return 9'd90;
      3'h3:       return 9'd120;
      3'h4:       return 9'd180;
      3'h5:       return 9'd210;
      3'h6:       return 9'd270;
      default:    return 9'd300;
    endcase
  endfunction

  function automatic logic [10:0] gdcfg_thresh_mv(input logic [2:0] code);
    case (code)
      3'h0:    return 11'd150;
      3'h1:    return 11'd240;
      3'h2:    return 11'd400;
      3'h3:    return 11'd510;
      3'h4:    return 11'd600;
      3'h5:    return 11'd900;
      3'h6:    return 11'd1800;
      default: return 11'd0;
    endcase
  endfunction

endpackage

// >>> verilog/gdcfg_retry_timer.sv
// gdcfg_retry_timer: one-shot overcurrent retry wait with two selectable lengths
module gdcfg_retry_timer
  import gdcfg_pkg::*;
#(
  parameter int unsigned LONG_CYC  = RETRY_LONG_CYC,
  parameter int unsigned SHORT_CYC = RETRY_SHRT_CYC
)(
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic start,
  input  wire logic short_sel,
  output logic      busy,
  output logic      done
);

  typedef enum logic [1:0] {T_IDLE = 2'b01, T_RUN = 2'b10} gdcfg_tstate_t;

  gdcfg_tstate_t state_q, state_d;
  logic [19:0]   cnt_q, cnt_d;
  logic          done_q, done_d;

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    case (state_q)
      T_IDLE:
      begin
        if (start)
        begin
          // length is picked at start; a later change of the select waits for the next fault
          cnt_d   = short_sel ? 20'(SHORT_CYC - 1) : 20'(LONG_CYC - 1);
          state_d = T_RUN;
        end
      end
      T_RUN:
      begin
        if (cnt_q == 20'h00000)
        begin
          done_d  = 1'b1;
          state_d = T_IDLE;
        end
        else
        begin
          cnt_d = cnt_q - 20'h00001;
        end
      end
      default: state_d = T_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= T_IDLE;
      cnt_q   <= 20'h00000;
      done_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      done_q  <= done_d;
    end
  end

  assign busy = (state_q == T_RUN);
  assign done = done_q;

endmodule // gdcfg_retry_timer

// >>> verilog/gdcfg_regs.sv
// gdcfg_regs: gate driver configuration bank with lock, decode and fault handling
//
// Overview of operation
// - pump undervoltage fault suppressed while its disable bit is set
// - gate drive fault suppressed while its disable bit holds one
// - overtemperature warning reaches fault pin and summary only when reporting enabled
// - single-input mode: rectify bit 0 synchronous, 1 diode freewheeling
// - single-input direction is register bit ORed with phase C high pin
// - coast bit set turns all six gates off
// - single-input mode: brake bit OR phase C low pin turns lows on unless coast bit is set
// - fault clear bit clears latched faults, then returns to zero itself
// - unlocked: writing 110b to lock field locks; other values ignored
// - locked: writes dropped except lock field and driver control bits 0-2
// - locked: writing 011b to lock field unlocks; other values ignored
// - source current codes decode to 15,15,45,60,90,105,135,150 mA
// - sink current codes decode to 30,30,90,120,180,210,270,300 mA
// - cycle clear in retry mode clears overcurrent faults on next pwm input
// - peak drive time codes give 500, 1000, 2000, 4000 ns
// - retry wait is 4 ms with select 0, 50 us with select 1
// - dead time codes give 50, 100, 200, 400 ns
// - response codes: latched, retrying, report only, ignored
// - latched or retrying overcurrent shuts all bridges with scope 0, only affected one with 1
// - threshold codes give 0.15..1.8 V; code 111b disables drain-source monitoring, sense overcurrent still taken
module gdcfg_regs
  import gdcfg_pkg::*;
#(
  parameter int unsigned RETRY_LONG  = RETRY_LONG_CYC,
  parameter int unsigned RETRY_SHORT = RETRY_SHRT_CYC
)(
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire gdcfg_req_t       req,
  output logic [10:0]           rdata,
  output logic                  rvalid,
  input  wire gdcfg_fault_in_t  fault_in,
  input  wire logic             phase_c_high_input,
  input  wire logic             phase_c_low_input,
  output gdcfg_pwm_t            pwm_mode,
  output logic                  single_input_rectify_select,
  output logic                  direction_eff,
  output logic                  gates_off,
  output logic                  low_side_brake,
  output logic                  fault_clear,
  output logic                  locked,
  output gdcfg_gate_t           gate_cfg,
  output logic [10:0]           threshold_mv,
  output logic                  drain_source_monitor_off,
  output logic [2:0]            bridge_shutdown,
  output logic [2:0]            overcurrent_flags,
  output logic                  pump_fault_active,
  output logic                  gate_fault_active,
  output logic                  fault_summary,
  output logic                  fault_output_pin_n
);

  typedef enum logic [1:0] {L_OPEN = 2'b01, L_SHUT = 2'b10} gdcfg_lock_t;

  ////////////////////////////////////////////////////////////////////////////////
  // register file and lock

  logic [10:0] drv_q, drv_d, ocp_q, ocp_d, ls_q, ls_d;
  logic [7:0]  hs_q, hs_d;
  gdcfg_lock_t lock_q, lock_d;
  logic [10:0] rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;
  logic        is_locked, wr_drv, wr_hs, wr_ls, wr_ocp;
  logic [2:0]  lock_wr;

  assign is_locked = (lock_q == L_SHUT);
  assign wr_drv    = req.wr && (req.addr == ADDR_DRV_CTRL);
  assign wr_hs     = req.wr && (req.addr == ADDR_HS_GATE);
  assign wr_ls     = req.wr && (req.addr == ADDR_LS_GATE);
  assign wr_ocp    = req.wr && (req.addr == ADDR_OCP_CTRL);
  assign lock_wr   = req.wdata[F_LOCK +: 3];

  always_comb
  begin
    drv_d  = drv_q;
    hs_d   = hs_q;
    ls_d   = ls_q;
    ocp_d  = ocp_q;
    lock_d = lock_q;
    drv_d[F_CLEAR] = 1'b0;
    if (wr_drv)
    begin
      if (is_locked)
        drv_d = (drv_q & ~LOCKED_WR_MASK) | (req.wdata & LOCKED_WR_MASK);
      else
        drv_d = req.wdata;
    end
    if (wr_hs && !is_locked)
      hs_d = req.wdata[7:0] & HS_STORE_MASK;
    if (wr_ls && !is_locked)
      ls_d = req.wdata;
    if (wr_ocp && !is_locked)
      ocp_d = req.wdata;
    case (lock_q)
      L_OPEN:  if (wr_hs && lock_wr == LOCK_KEY) lock_d = L_SHUT;
      L_SHUT:  if (wr_hs && lock_wr == UNLOCK_KEY) lock_d = L_OPEN;
      default: lock_d = L_OPEN;
    endcase
    rvalid_d = req.rd;
    // unmapped and status offsets read zero; lock field reads back its key
    if (req.addr == ADDR_DRV_CTRL)
      rdata_d = drv_q;
    else if (req.addr == ADDR_HS_GATE)
      rdata_d = {(is_locked ? LOCK_KEY : UNLOCK_KEY), hs_q};
    else if (req.addr == ADDR_LS_GATE)
      rdata_d = ls_q;
    else if (req.addr == ADDR_OCP_CTRL)
      rdata_d = ocp_q;
    else
      rdata_d = 11'h000;
    if (!req.rd)
      rdata_d = rdata_q;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      drv_q    <= RST_DRV_CTRL;
      hs_q     <= RST_HS_GATE[7:0];
      ls_q     <= RST_LS_GATE;
      ocp_q    <= RST_OCP_CTRL;
      lock_q   <= L_OPEN;
      rdata_q  <= 11'h000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      drv_q    <= drv_d;
      hs_q     <= hs_d;
      ls_q     <= ls_d;
      ocp_q    <= ocp_d;
      lock_q   <= lock_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign rdata       = rdata_q;
  assign rvalid      = rvalid_q;
  assign locked      = is_locked;
  assign fault_clear = drv_q[F_CLEAR];

  ////////////////////////////////////////////////////////////////////////////////
  // fault latching and overcurrent response

  gdcfg_ocr_t  oc_resp;
  logic [2:0]  oc_q, oc_d, oc_ev;
  logic        pump_q, pump_d, gate_q, gate_d;
  logic        retry_busy, retry_done, retry_start, oc_clr, ds_off;

  assign oc_resp = gdcfg_ocr_t'(ocp_q[F_OC_RESP +: 2]);
  assign ds_off  = (ocp_q[F_THRESH +: 3] == THRESH_OFF);

  always_comb
  begin
    // ignore mode neither flags nor acts, so no event is taken at all
    oc_ev = ({3{!ds_off}} & fault_in.drain_source_overcurrent) | fault_in.sense_overcurrent;
    if (oc_resp == OC_IGNORE)
      oc_ev = 3'h0;
    oc_clr = fault_clear;
    if (oc_resp == OC_RETRY)
      oc_clr = fault_clear || retry_done ||
               (ls_q[F_CYCLE_CLR] && fault_in.pwm_edge);
    retry_start = (oc_resp == OC_RETRY) && (|oc_ev) && !retry_busy;
    // a new event in the clearing cycle wins over the clear
    oc_d   = oc_ev | (oc_q & ~{3{oc_clr}});
    pump_d = !drv_q[F_PUMP_DIS] && (fault_in.pump_uv || (pump_q && !fault_clear));
    gate_d = !drv_q[F_GATE_DIS] && (fault_in.gate_fault || (gate_q && !fault_clear));
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      oc_q   <= 3'h0;
      pump_q <= 1'b0;
      gate_q <= 1'b0;
    end
    else
    begin
      oc_q   <= oc_d;
      pump_q <= pump_d;
      gate_q <= gate_d;
    end
  end

  gdcfg_retry_timer #(
    .LONG_CYC  (RETRY_LONG),
    .SHORT_CYC (RETRY_SHORT)
  ) u_retry (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .start     (retry_start),
    .short_sel (ocp_q[F_RETRY_SEL]),
    .busy      (retry_busy),
    .done      (retry_done)
  );

  assign overcurrent_flags = oc_q;
  assign pump_fault_active = pump_q;
  assign gate_fault_active = gate_q;

  ////////////////////////////////////////////////////////////////////////////////
  // decoded outputs, all registered

  gdcfg_pwm_t  mode_q, mode_d;
  gdcfg_gate_t gcfg_q, gcfg_d;
  logic [10:0] thr_q, thr_d;
  logic [2:0]  shut_q, shut_d;
  logic        rect_q, rect_d, dir_q, dir_d, off_q, off_d, brk_q, brk_d;
  logic        dsoff_q, dsoff_d, sum_q, sum_d, act;

  always_comb
  begin
    case (drv_q[F_PWM_MODE +: 2])
      2'h0:    mode_d = PWM_SIX;
      2'h1:    mode_d = PWM_THREE;
      2'h2:    mode_d = PWM_SINGLE;
      default: mode_d = PWM_INDEP;
    endcase
    rect_d = (mode_d == PWM_SINGLE) && drv_q[F_RECT];
    dir_d  = (mode_d == PWM_SINGLE) && (drv_q[F_DIR] || phase_c_high_input);
    off_d  = drv_q[F_COAST];
    // coast outranks brake so a coasting bridge never has a low side on
    brk_d  = (mode_d == PWM_SINGLE) && !drv_q[F_COAST] &&
             (drv_q[F_BRAKE] || phase_c_low_input);
    gcfg_d.high_source_ma = gdcfg_source_ma(hs_q[F_SOURCE +: 3]);
    gcfg_d.low_source_ma  = gdcfg_source_ma(ls_q[F_SOURCE +: 3]);
    gcfg_d.high_sink_ma   = gdcfg_sink_ma(hs_q[F_SINK +: 3]);
    gcfg_d.low_sink_ma    = gdcfg_sink_ma(ls_q[F_SINK +: 3]);
    gcfg_d.drive_cycles   = 16'(DRIVE_BASE_CYC) << ls_q[F_DRIVE_TIME +: 2];
    gcfg_d.dead_cycles    = 16'(DEAD_BASE_CYC) << ocp_q[F_DEAD +: 2];
    thr_d   = gdcfg_thresh_mv(ocp_q[F_THRESH +: 3]);
    dsoff_d = ds_off;
    act     = (oc_resp == OC_LATCH) || (oc_resp == OC_RETRY);
    if (!act)
      shut_d = 3'h0;
    else if (ocp_q[F_SCOPE])
      shut_d = oc_q;
    else
      shut_d = {3{|oc_q}};
    sum_d = pump_q || gate_q || ((oc_resp != OC_IGNORE) && (|oc_q)) ||
            (drv_q[F_WARN_REP] && fault_in.overtemp_warning);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_q  <= PWM_SIX;
      gcfg_q  <= '0;
      thr_q   <= 11'h000;
      shut_q  <= 3'h0;
      rect_q  <= 1'b0;
      dir_q   <= 1'b0;
      off_q   <= 1'b0;
      brk_q   <= 1'b0;
      dsoff_q <= 1'b0;
      sum_q   <= 1'b0;
    end
    else
    begin
      mode_q  <= mode_d;
      gcfg_q  <= gcfg_d;
      thr_q   <= thr_d;
      shut_q  <= shut_d;
      rect_q  <= rect_d;
      dir_q   <= dir_d;
      off_q   <= off_d;
      brk_q   <= brk_d;
      dsoff_q <= dsoff_d;
      sum_q   <= sum_d;
    end
  end

  assign pwm_mode                    = mode_q;
  assign gate_cfg                    = gcfg_q;
  assign threshold_mv                = thr_q;
  assign bridge_shutdown             = shut_q;
  assign single_input_rectify_select = rect_q;
  assign direction_eff               = dir_q;
  assign gates_off                   = off_q;
  assign low_side_brake              = brk_q;
  assign drain_source_monitor_off    = dsoff_q;
  assign fault_summary               = sum_q;
  assign fault_output_pin_n          = !sum_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  pump_suppress_a: assert property (drv_q[F_PUMP_DIS] |=> !pump_fault_active)
    else $error("pump fault seen while disabled");
  gate_suppress_a: assert property (drv_q[F_GATE_DIS] |=> !gate_fault_active)
    else $error("gate fault seen while disabled");
  warn_report_a: assert property (drv_q[F_WARN_REP] && fault_in.overtemp_warning |=> !fault_output_pin_n)
    else $error("reported warning missing on fault pin");
  dir_or_a: assert property (drv_q[F_PWM_MODE +: 2] == 2'h2 && phase_c_high_input |=> direction_eff)
    else $error("direction not ORed with pin");
  coast_off_a: assert property ($rose(drv_q[F_COAST]) |=> gates_off && !low_side_brake)
    else $error("coast did not turn gates off");
  clear_self_a: assert property (fault_clear && !(wr_drv && req.wdata[F_CLEAR]) |=> !fault_clear)
    else $error("fault clear bit stuck");
  lock_enter_a: assert property (!locked && wr_hs && lock_wr == LOCK_KEY |=> locked)
    else $error("lock key did not lock");
  locked_drop_a: assert property (locked && (wr_ocp || wr_ls) |=> $stable(ocp_q) && $stable(ls_q))
    else $error("locked write changed a register");
  unlock_key_a: assert property (locked && wr_hs |=> locked == ($past(lock_wr) != UNLOCK_KEY))
    else $error("unlock key mishandled");
  scope_all_a: assert property (oc_resp == OC_LATCH && !ocp_q[F_SCOPE] && |oc_q && $stable(ocp_q)
                                |=> bridge_shutdown == 3'h7)
    else $error("all bridges not shut down");

  lock_cycle_c: cover property (lock_q == L_OPEN ##1 locked [*2] ##1 !locked);
  retry_done_c: cover property (retry_start ##[1:300] oc_q == 3'h0);
  brake_c:      cover property (low_side_brake && !gates_off);

endmodule // gdcfg_regs

// >>> verif/gdcfg_host.sv
// gdcfg_host: host model that drives the register port of the configuration bank
module gdcfg_host
  import gdcfg_pkg::*;
(
  input  wire logic        core_clk,
  output gdcfg_req_t       req,
  input  wire logic [10:0] rdata,
  input  wire logic        rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // write is taken at the edge after the strobe rises; released data is inverted
  // so a design that samples late never sees the old word by luck
  task automatic wr(input logic [3:0] a, input logic [10:0] x);
    @(posedge core_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: x};
    @(posedge core_clk);
    req.wr <= 1'b0;
    req.wdata <= ~x;
  endtask

  // answer stands right after the taking edge and is read 1 ns later
  task automatic rd(input logic [3:0] a, output logic [10:0] x, output logic v);
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 11'h000};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    x = rdata;
    v = rvalid;
  endtask
endmodule // gdcfg_host

// >>> verif/testbench.sv
// testbench: directed register, decode and fault tests of the configuration bank
module testbench
  import gdcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // short retry counts keep the run brief
  localparam int unsigned LNG = 40;
  localparam int unsigned SHT = 10;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  gdcfg_req_t req;
  gdcfg_fault_in_t fi = '0;
  logic pch = 1'b0;
  logic pcl = 1'b0;
  logic [10:0] rdata, thr, d;
  logic rvalid, rect, dir, off, brk, fclr, locked, moff, fsum, pin_n, pump, gate, v;
  gdcfg_pwm_t pwm_mode;
  gdcfg_gate_t gate_cfg;
  logic [2:0] shut, ocf;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [8:0] src_t [8] = '{15, 15, 45, 60, 90, 105, 135, 150};
  logic [10:0] thr_t [8] = '{150, 240, 400, 510, 600, 900, 1800, 0};
  logic [10:0] rst_t [6] = '{11'h000, 11'h377, 11'h777, 11'h145, 11'h000, 11'h000};
  // word, phase c high pin, phase c low pin, expected rect/dir/coast/brake
  logic [16:0] sm_t [8] = '{{11'h040, 6'h24}, {11'h048, 6'h04}, {11'h040, 6'h11}, {11'h042, 6'h01},
                            {11'h050, 6'h08}, {11'h044, 6'h12}, {11'h000, 6'h30}, {11'h004, 6'h02}};

  initial forever #2.5 core_clk = ~core_clk;

  gdcfg_host host (.core_clk, .req, .rdata, .rvalid);

  gdcfg_regs #(.RETRY_LONG(LNG), .RETRY_SHORT(SHT)) dut (
    .core_clk, .rstn, .req, .rdata, .rvalid, .fault_in(fi), .phase_c_high_input(pch),
    .phase_c_low_input(pcl), .pwm_mode, .single_input_rectify_select(rect), .direction_eff(dir),
    .gates_off(off), .low_side_brake(brk), .fault_clear(fclr), .locked, .gate_cfg, .threshold_mv(thr),
    .drain_source_monitor_off(moff), .bridge_shutdown(shut), .overcurrent_flags(ocf),
    .pump_fault_active(pump), .gate_fault_active(gate), .fault_summary(fsum), .fault_output_pin_n(pin_n));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [67:0] s, input logic [67:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic st(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic pulse(input gdcfg_fault_in_t p);
    @(posedge core_clk);
    fi <= p;
    @(posedge core_clk);
    fi <= '0;
  endtask

  // clear, set the overcurrent word, fire one event, look early and after wt cycles
  task automatic oc(input logic [10:0] w, input gdcfg_fault_in_t p, input logic [2:0] sh,
                    input logic [2:0] f1, input int wt, input logic [2:0] f2);
    host.wr(ADDR_DRV_CTRL, 11'h001);
    host.wr(ADDR_OCP_CTRL, w);
    st(2);
    pulse(p);
    st(2);
    check(ocf, f1);
    check(shut, sh);
    st(wt);
    check(ocf, f2);
  endtask

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    st(2);
    check(gate_cfg, {9'd150, 9'd300, 9'd150, 9'd300, 16'd800, 16'd20});
    check(thr, 11'd900);
    for (int i = 0; i < 6; i++)
    begin
      host.rd(4'(i + 2), d, v);
      check({v, d}, {1'b1, rst_t[i]});
    end
    for (int i = 0; i < 8; i++)
    begin
      host.wr(ADDR_HS_GATE, {3'h3, 1'b0, 3'(i), 1'b0, 3'(i)});
      host.wr(ADDR_LS_GATE, {1'b0, 2'(i), 1'b1, 3'(7 - i), 1'b1, 3'(7 - i)});
      host.wr(ADDR_OCP_CTRL, {1'b0, 2'(i), 2'h3, 1'b0, 2'h0, 3'(i)});
      st(3);
      check({gate_cfg.high_source_ma, gate_cfg.high_sink_ma}, {src_t[i], 9'(2 * src_t[i])});
      check({gate_cfg.low_source_ma, gate_cfg.low_sink_ma}, {src_t[7 - i], 9'(2 * src_t[7 - i])});
      check(gate_cfg.drive_cycles, 16'd100 << i[1:0]);
      check(gate_cfg.dead_cycles, 16'd10 << i[1:0]);
      check({moff, thr}, {i == 7, thr_t[i]});
      host.rd(ADDR_LS_GATE, d, v);
      check(d, {1'b0, 2'(i), 1'b1, 3'(7 - i), 1'b1, 3'(7 - i)});
    end
    for (int i = 0; i < 4; i++)
    begin
      host.wr(ADDR_DRV_CTRL, {1'b1, 3'h0, 2'(i), 5'h00});
      st(3);
      check(pwm_mode, 4'h1 << i);
      host.rd(ADDR_DRV_CTRL, d, v);
      check(d, {1'b1, 3'h0, 2'(i), 5'h00});
    end
    foreach (sm_t[i])
    begin
      host.wr(ADDR_DRV_CTRL, sm_t[i][16:6]);
      pch <= sm_t[i][5];
      pcl <= sm_t[i][4];
      st(3);
      check({rect, dir, off, brk}, sm_t[i][3:0]);
    end
    host.wr(ADDR_HS_GATE, 11'h577);
    st(1);
    check(locked, 1'b0);
    host.wr(ADDR_HS_GATE, 11'h677);
    st(1);
    check(locked, 1'b1);
    host.wr(ADDR_LS_GATE, 11'h111);
    host.wr(ADDR_OCP_CTRL, 11'h000);
    host.wr(ADDR_DRV_CTRL, 11'h7fe);
    host.wr(ADDR_HS_GATE, 11'h500);
    host.rd(ADDR_LS_GATE, d, v);
    check(d, 11'h388);
    host.rd(ADDR_OCP_CTRL, d, v);
    check(d, 11'h3c7);
    host.rd(ADDR_DRV_CTRL, d, v);
    check(d, 11'h006);
    host.rd(ADDR_HS_GATE, d, v);
    check({locked, d}, {1'b1, 11'h677});
    host.wr(ADDR_HS_GATE, 11'h300);
    host.rd(ADDR_HS_GATE, d, v);
    check({locked, d}, {1'b0, 11'h377});
    for (int i = 0; i < 2; i++)
    begin
      host.wr(ADDR_DRV_CTRL, 11'h000);
      pulse(i ? 10'h100 : 10'h200);
      st(2);
      check({pump, gate, fsum, pin_n}, i ? 4'b0110 : 4'b1010);
      host.wr(ADDR_DRV_CTRL, 11'h001);
      st(0);
      check(fclr, 1'b1);
      st(3);
      check({pump, gate, fsum, fclr}, 4'b0000);
      host.rd(ADDR_DRV_CTRL, d, v);
      check(d, 11'h000);
      host.wr(ADDR_DRV_CTRL, i ? 11'h100 : 11'h200);
      pulse(i ? 10'h100 : 10'h200);
      st(2);
      check({pump, gate}, 2'b00);
    end
    for (int i = 0; i < 2; i++)
    begin
      host.wr(ADDR_DRV_CTRL, i ? 11'h080 : 11'h000);
      @(posedge core_clk);
      fi.overtemp_warning <= 1'b1;
      st(3);
      check({fsum, pin_n}, i ? 2'b10 : 2'b01);
      @(posedge core_clk);
      fi.overtemp_warning <= 1'b0;
    end
    host.wr(ADDR_LS_GATE, 11'h377);
    oc(11'h545, 10'h020, 3'h7, 3'h2, 15, 3'h0);
    oc(11'h565, 10'h008, 3'h4, 3'h4, 15, 3'h0);
    oc(11'h505, 10'h020, 3'h7, 3'h2, 15, 3'h2);
    oc(11'h585, 10'h020, 3'h0, 3'h2, 15, 3'h2);
    oc(11'h5c5, 10'h020, 3'h0, 3'h0, 15, 3'h0);
    oc(11'h145, 10'h020, 3'h7, 3'h2, 15, 3'h2);
    st(35);
    check(ocf, 3'h0);
    host.wr(ADDR_LS_GATE, 11'h777);
    oc(11'h145, 10'h010, 3'h7, 3'h1, 0, 3'h1);
    pulse(10'h001);
    st(2);
    check(ocf, 3'h0);
    end_sim();
  end
endmodule // testbench
